/* File: hw/cefl_defs.svh */
// Offsets, field positions, reset values and counts of the error-flag block.
// Functional notes
// - Watch on: checksum changes raise register-change flag.
// - Register-change flag holds until watch written 0.
// - Data, status, interface mode registers are unwatched.
// - Mode 10: open-drain pin shows OR of flags.
// - Mode 01: inverted pin ORed into conversion fault.
// - Mode 01: pin level readable in level bit.
// - Mode 00 disables pin; 11 makes general output.
// - Append enable adds status after each result.
// - Appended status low two bits hold channel.
// - General output mode drives the level bit.
// - Range faults set conversion fault; data read keeps it.
// - Bad write checksum sets flag; status read clears.
`ifndef CEFL_DEFS_SVH
`define CEFL_DEFS_SVH

// Register indices; the byte address is four times the index.
`define CEFL_IDX_STATUS   8'h00
`define CEFL_IDX_ADCMODE  8'h01
`define CEFL_IDX_INTERFACE_MODE_REGISTER   8'h02
`define CEFL_IDX_REGSUM   8'h03
`define CEFL_IDX_DATA     8'h04
`define CEFL_IDX_PINCFG   8'h06
`define CEFL_IDX_CHAN0    8'h10
`define CEFL_IDX_INTSTAT  8'h30
`define CEFL_IDX_INTMASK  8'h31

// Reset values.
`define CEFL_RST_ADCMODE  16'h2000
`define CEFL_RST_INTERFACE_MODE_REGISTER   16'h0000
`define CEFL_RST_PINCFG   16'h0800
`define CEFL_RST_CHAN0    16'h8001

// Status byte fields.
`define CEFL_ST_CONV      6
`define CEFL_ST_CRC       5
`define CEFL_ST_REG       4

// Interface mode fields.
`define CEFL_IF_APPEND    6
`define CEFL_IF_WATCH     5

// Pin configuration fields.
`define CEFL_PC_MODE_HI   10
`define CEFL_PC_MODE_LO   9
`define CEFL_PC_LEVEL     8

// Interrupt status bits.
`define CEFL_IRQ_CONV     0
`define CEFL_IRQ_CRC      1
`define CEFL_IRQ_REG      2
`define CEFL_IRQ_RESULT   3
`define CEFL_IRQ_BITS     4

// Checksum width.
`define CEFL_SUM_W        24

`endif

/* File: hw/cefl_pkg.sv */
// Types shared by the error-flag block.
`default_nettype none
package cefl_pkg;
    // Fault pin function, in field encoding order 00, 01, 10, 11.
    typedef enum logic [1:0] {
        CEFL_PIN_OFF,
        CEFL_PIN_IN,
        CEFL_PIN_ERR_OUT,
        CEFL_PIN_GPO
    } cefl_pin_mode_t;

    typedef logic [31:0] cefl_word_t;
endpackage : cefl_pkg
`default_nettype wire

/* File: hw/cefl_sum.sv */
// Folding checksum over the watched register bits.
`include "cefl_defs.svh"
`default_nettype none
module cefl_sum #(
    parameter int IN_W  = 48,
    parameter int SUM_W = `CEFL_SUM_W
) (
    input  wire logic [IN_W-1:0]  i_bits,
    output logic      [SUM_W-1:0] o_sum
);
    // Each checksum bit is the parity of every SUM_W-th input bit, so any
    // single-bit change always flips exactly one checksum bit.
    genvar k;
    generate
        for (k = 0; k < SUM_W; k++) begin : g_fold
            always_comb begin
                logic acc;
                acc = 1'b0;
                for (int j = k; j < IN_W; j += SUM_W) begin
                    acc = acc ^ i_bits[j];
                end
                o_sum[k] = acc;
            end
        end
    endgenerate
endmodule : cefl_sum
`default_nettype wire

/* File: hw/cefl_top.sv */
// Error flags, fault pin and status append of the converter, on AHB-Lite.
//
// The AHB-Lite register port and the placing of the registers were chosen for this implementation.
`include "cefl_defs.svh"
`default_nettype none
module cefl_top (
    input  wire logic        I_CLOCK,
    input  wire logic        I_ARST_N,
    input  wire logic        I_HSEL,
    input  wire logic [31:0] I_HADDR,
    input  wire logic [1:0]  I_HTRANS,
    input  wire logic        I_HWRITE,
    input  wire logic [2:0]  I_HSIZE,
    input  wire logic [31:0] I_HWDATA,
    input  wire logic        I_HREADY,
    output logic             O_HREADYOUT,
    output logic             O_HRESP,
    output logic      [31:0] O_HRDATA,
    input  wire logic        I_RESULT_VALID,
    input  wire logic [23:0] I_RESULT,
    input  wire logic [1:0]  I_RESULT_CHAN,
    input  wire logic        I_RANGE_FAULT,
    input  wire logic        I_CRC_BAD,
    output logic             O_OUT_VALID,
    output logic      [31:0] O_OUT_DATA,
    output logic             O_OUT_STATUS_ON,
    input  wire logic        I_FAULT_PIN,
    output logic             O_FAULT_PIN,
    output logic             O_FAULT_PIN_OE,
    output logic             O_IRQ
);
    localparam int WATCH_W = 48;

    logic [15:0]                adcmode;
    logic [15:0]                interface_mode_register;
    logic [15:0]                pincfg;
    logic [15:0]                chan0;
    logic [23:0]                data;
    logic [1:0]                 last_chan;
    logic                       range_flag;
    logic                       crc_fault;
    logic                       reg_change;
    logic                       pin_level;
    logic                       watch_q;
    logic [`CEFL_SUM_W-1:0]     ref_sum;
    logic [`CEFL_SUM_W-1:0]     cur_sum;
    logic [WATCH_W-1:0]         watched;
    logic [`CEFL_IRQ_BITS-1:0]  int_stat;
    logic [`CEFL_IRQ_BITS-1:0]  int_mask;
    logic [`CEFL_IRQ_BITS-1:0]  events;
    logic                       dp_write;
    logic [7:0]                 dp_idx;
    logic                       ap_take;
    logic [7:0]                 ap_idx;
    logic                       wr_now;
    logic                       rd_status;
    logic                       conv_fault;
    logic                       conv_fault_q;
    logic                       watch_on;
    logic                       mismatch;
    logic [7:0]                 status_byte;
    logic [7:0]                 next_status;
    logic [15:0]                pincfg_view;
    cefl_pkg::cefl_pin_mode_t   pin_mode;

    // True when a register index matches the given one.
    function automatic logic hit(input logic [7:0] idx,
                                 input logic [7:0] want);
        hit = (idx == want);
    endfunction : hit

    // Address phase is taken when selected, active and the bus is ready.
    assign ap_take   = I_HSEL && I_HTRANS[1] && I_HREADY;
    assign ap_idx    = I_HADDR[9:2];
    assign wr_now    = dp_write;
    assign rd_status = ap_take && !I_HWRITE
                       && hit(ap_idx, `CEFL_IDX_STATUS);
    assign O_HREADYOUT = 1'b1;
    assign O_HRESP     = 1'b0;

    // Latch the write address for the following data phase.
    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            dp_write <= 1'b0;
            dp_idx   <= 8'h00;
        end else begin
            dp_write <= ap_take && I_HWRITE;
            if (ap_take) begin
                dp_idx <= ap_idx;
            end
        end
    end

    // Pin mode decode and the merged conversion fault.
    assign pin_mode   = cefl_pkg::cefl_pin_mode_t'(
        pincfg[`CEFL_PC_MODE_HI:`CEFL_PC_MODE_LO]);
    assign conv_fault = range_flag
        || (pin_mode == cefl_pkg::CEFL_PIN_IN && !pin_level);
    assign watch_on   = interface_mode_register[`CEFL_IF_WATCH];

    // In input mode the level bit shows the sampled pin.
    always_comb begin
        pincfg_view = pincfg;
        if (pin_mode == cefl_pkg::CEFL_PIN_IN) begin
            pincfg_view[`CEFL_PC_LEVEL] = pin_level;
        end
    end

    // Status byte: flags plus channel of the latest result.
    assign status_byte = {1'b0, conv_fault, crc_fault, reg_change,
                          2'b00, last_chan};
    assign next_status = {1'b0, I_RANGE_FAULT || (!pin_level && pin_mode
                          == cefl_pkg::CEFL_PIN_IN), crc_fault, reg_change,
                          2'b00, I_RESULT_CHAN};

    // Software-held configuration registers.
    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            adcmode <= `CEFL_RST_ADCMODE;
            interface_mode_register  <= `CEFL_RST_INTERFACE_MODE_REGISTER;
            pincfg  <= `CEFL_RST_PINCFG;
            chan0   <= `CEFL_RST_CHAN0;
        end else if (wr_now) begin
            if (hit(dp_idx, `CEFL_IDX_ADCMODE)) begin
                adcmode <= I_HWDATA[15:0];
            end
            if (hit(dp_idx, `CEFL_IDX_INTERFACE_MODE_REGISTER)) begin
                interface_mode_register <= I_HWDATA[15:0];
            end
            if (hit(dp_idx, `CEFL_IDX_PINCFG)) begin
                pincfg <= I_HWDATA[15:0];
            end
            if (hit(dp_idx, `CEFL_IDX_CHAN0)) begin
                chan0 <= I_HWDATA[15:0];
            end
        end
    end

    // Watched bits leave out data, status and interface mode, and the
    // level bit, which follows the pin in input mode.
    assign watched = {adcmode, pincfg[15:9], 1'b0, pincfg[7:0],
                      chan0};

    cefl_sum #(
        .IN_W  (WATCH_W),
        .SUM_W (`CEFL_SUM_W)
    ) u_sum (
        .i_bits (watched),
        .o_sum  (cur_sum)
    );

    assign mismatch = watch_on && watch_q && (cur_sum != ref_sum);

    // Reference checksum is caught as the watch turns on.
    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            watch_q <= 1'b0;
            ref_sum <= '0;
        end else begin
            watch_q <= watch_on;
            if (watch_on && !watch_q) begin
                ref_sum <= cur_sum;
            end
        end
    end

    // Register-change flag holds until the watch is switched off.
    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            reg_change <= 1'b0;
        end else if (mismatch) begin
            reg_change <= 1'b1;
        end else if (!watch_on) begin
            reg_change <= 1'b0;
        end
    end

    // Checksum fault: set by a bad write, cleared by a status read.
    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            crc_fault <= 1'b0;
        end else if (I_CRC_BAD) begin
            crc_fault <= 1'b1;
        end else if (rd_status) begin
            crc_fault <= 1'b0;
        end
    end

    // Range state follows each result; data reads leave it alone.
    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            range_flag <= 1'b0;
            data       <= 24'h000000;
            last_chan  <= 2'b00;
            pin_level  <= 1'b1;
        end else begin
            pin_level <= I_FAULT_PIN;
            if (I_RESULT_VALID) begin
                range_flag <= I_RANGE_FAULT;
                data       <= I_RESULT;
                last_chan  <= I_RESULT_CHAN;
            end
        end
    end

    // Result output, with the status byte appended when enabled.
    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_OUT_VALID     <= 1'b0;
            O_OUT_DATA      <= 32'h00000000;
            O_OUT_STATUS_ON <= 1'b0;
        end else begin
            O_OUT_VALID <= I_RESULT_VALID;
            if (I_RESULT_VALID) begin
                O_OUT_STATUS_ON <= interface_mode_register[`CEFL_IF_APPEND];
                if (interface_mode_register[`CEFL_IF_APPEND]) begin
                    O_OUT_DATA <= {I_RESULT, next_status};
                end else begin
                    O_OUT_DATA <= {8'h00, I_RESULT};
                end
            end
        end
    end

    // Fault pin driver per function field.
    always_comb begin
        O_FAULT_PIN    = 1'b1;
        O_FAULT_PIN_OE = 1'b0;
        case (pin_mode)
            cefl_pkg::CEFL_PIN_ERR_OUT: begin
                O_FAULT_PIN    = 1'b0;
                O_FAULT_PIN_OE = conv_fault || crc_fault || reg_change;
            end
            cefl_pkg::CEFL_PIN_GPO: begin
                O_FAULT_PIN    = pincfg[`CEFL_PC_LEVEL];
                O_FAULT_PIN_OE = 1'b1;
            end
            cefl_pkg::CEFL_PIN_IN: begin
                O_FAULT_PIN_OE = 1'b0;
            end
            default: begin
                O_FAULT_PIN_OE = 1'b0;
            end
        endcase
    end

    // Interrupt events are rising flags and each result.
    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            conv_fault_q <= 1'b0;
        end else begin
            conv_fault_q <= conv_fault;
        end
    end
    assign events = {I_RESULT_VALID, mismatch && !reg_change,
                     I_CRC_BAD && !crc_fault, conv_fault && !conv_fault_q};

    // Sticky interrupt status, write one to clear, set wins.
    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            int_stat <= '0;
            int_mask <= '0;
        end else begin
            if (wr_now && hit(dp_idx, `CEFL_IDX_INTSTAT)) begin
                int_stat <= (int_stat & ~I_HWDATA[`CEFL_IRQ_BITS-1:0])
                            | events;
            end else begin
                int_stat <= int_stat | events;
            end
            if (wr_now && hit(dp_idx, `CEFL_IDX_INTMASK)) begin
                int_mask <= I_HWDATA[`CEFL_IRQ_BITS-1:0];
            end
        end
    end
    assign O_IRQ = |(int_stat & int_mask);

    // Read data is prepared in the address phase and held by a flop.
    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_HRDATA <= 32'h00000000;
        end else if (ap_take && !I_HWRITE) begin
            case (ap_idx)
                `CEFL_IDX_STATUS:  O_HRDATA <= {24'h000000, status_byte};
                `CEFL_IDX_ADCMODE: O_HRDATA <= {16'h0000, adcmode};
                `CEFL_IDX_INTERFACE_MODE_REGISTER:  O_HRDATA <= {16'h0000, interface_mode_register};
                `CEFL_IDX_REGSUM:  O_HRDATA <= {8'h00, cur_sum};
                `CEFL_IDX_DATA:    O_HRDATA <= {8'h00, data};
                `CEFL_IDX_PINCFG:  O_HRDATA <= {16'h0000, pincfg_view};
                `CEFL_IDX_CHAN0:   O_HRDATA <= {16'h0000, chan0};
                `CEFL_IDX_INTSTAT: O_HRDATA <= {28'h0000000, int_stat};
                `CEFL_IDX_INTMASK: O_HRDATA <= {28'h0000000, int_mask};
                default:           O_HRDATA <= 32'h00000000;
            endcase
        end
    end

    // Checks of the flag, pin and append behaviour.
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_ARST_N);

    reg_change_set_a: assert property (
        mismatch |=> reg_change)
        else $error("Register change not flagged.");
    watch_clear_a: assert property (
        reg_change && !watch_on |=> !reg_change)
        else $error("Register change flag not cleared by watch off.");
    ref_capture_a: assert property (
        $rose(watch_on) |=> ref_sum == $past(cur_sum) && !reg_change)
        else $error("Reference checksum not captured.");
    err_pin_a: assert property (
        pin_mode == cefl_pkg::CEFL_PIN_ERR_OUT |->
        !O_FAULT_PIN && O_FAULT_PIN_OE == (conv_fault || crc_fault
        || reg_change))
        else $error("Error output pin wrong.");
    pin_input_a: assert property (
        pin_mode == cefl_pkg::CEFL_PIN_IN && !I_FAULT_PIN ##1
        pin_mode == cefl_pkg::CEFL_PIN_IN |-> conv_fault
        && !O_FAULT_PIN_OE)
        else $error("Pin input not merged into conversion fault.");
    level_read_a: assert property (
        ap_take && !I_HWRITE && hit(ap_idx, `CEFL_IDX_PINCFG)
        && pin_mode == cefl_pkg::CEFL_PIN_IN
        |=> O_HRDATA[`CEFL_PC_LEVEL] == $past(pin_level))
        else $error("Pin level not readable.");
    pin_off_a: assert property (
        pin_mode == cefl_pkg::CEFL_PIN_OFF |-> !O_FAULT_PIN_OE)
        else $error("Disabled pin is driven.");
    gpo_a: assert property (
        pin_mode == cefl_pkg::CEFL_PIN_GPO |->
        O_FAULT_PIN_OE && O_FAULT_PIN == pincfg[`CEFL_PC_LEVEL])
        else $error("General output level wrong.");
    append_a: assert property (
        I_RESULT_VALID && interface_mode_register[`CEFL_IF_APPEND] |=> O_OUT_VALID
        && O_OUT_STATUS_ON && O_OUT_DATA[31:8] == $past(I_RESULT))
        else $error("Status not appended.");
    chan_bits_a: assert property (
        I_RESULT_VALID && interface_mode_register[`CEFL_IF_APPEND]
        |=> O_OUT_DATA[1:0] == $past(I_RESULT_CHAN))
        else $error("Channel bits wrong in appended status.");
    range_a: assert property (
        I_RESULT_VALID && I_RANGE_FAULT |=> conv_fault ##1
        (conv_fault || $past(I_RESULT_VALID)))
        else $error("Range fault lost.");
    crc_a: assert property (
        I_CRC_BAD |=> crc_fault)
        else $error("Checksum fault not set.");

    reg_change_c: cover property ($rose(reg_change));
    crc_clear_c:  cover property (crc_fault ##1 rd_status ##1 !crc_fault);
    append_c:     cover property (O_OUT_VALID && O_OUT_STATUS_ON);
    irq_c:        cover property ($rose(O_IRQ));
endmodule : cefl_top
`default_nettype wire

/* File: testbench/cefl_fault_peer.sv */
// Fault-pin neighbour: pull-up wire plus an external open-drain error output.
`default_nettype none
module cefl_fault_peer (
    input  wire logic i_oe,
    input  wire logic i_drive,
    input  wire logic i_ext_err,
    output logic      o_level
);
    timeunit 1ns;
    timeprecision 1ns;

    // The outside part only ever pulls low; otherwise the pull-up or the
    // device's own drive sets the level.
    always_comb begin
        if (i_ext_err) begin
            o_level = 1'b0;
        end else if (i_oe) begin
            o_level = i_drive;
        end else begin
            o_level = 1'b1;
        end
    end
endmodule : cefl_fault_peer
`default_nettype wire

/* File: testbench/cefl_top_tb.sv */
// Self-checking bench of the error-flag block over AHB-Lite.
`include "cefl_defs.svh"
`default_nettype none
module cefl_top_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk;
    logic        arst_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        hready;
    logic        hresp;
    logic [31:0] hrdata;
    logic        rv;
    logic [23:0] res;
    logic [1:0]  rch;
    logic        rng;
    logic        crc;
    logic        out_valid;
    logic [31:0] out_data;
    logic        out_st;
    logic        pin_lvl;
    logic        pin_drv;
    logic        pin_oe;
    logic        irq;
    logic        ext_err;
    int          fail_count;
    int          num_checks;
    logic [31:0] v;

    cefl_top dut_u (
        .I_CLOCK(clk), .I_ARST_N(arst_n), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
        .I_HWDATA(hwdata), .I_HREADY(hready), .O_HREADYOUT(hready),
        .O_HRESP(hresp), .O_HRDATA(hrdata), .I_RESULT_VALID(rv),
        .I_RESULT(res), .I_RESULT_CHAN(rch), .I_RANGE_FAULT(rng),
        .I_CRC_BAD(crc), .O_OUT_VALID(out_valid), .O_OUT_DATA(out_data),
        .O_OUT_STATUS_ON(out_st), .I_FAULT_PIN(pin_lvl),
        .O_FAULT_PIN(pin_drv), .O_FAULT_PIN_OE(pin_oe), .O_IRQ(irq)
    );

    cefl_fault_peer peer_u (
        .i_oe(pin_oe), .i_drive(pin_drv), .i_ext_err(ext_err),
        .o_level(pin_lvl)
    );

    // Free-running 50 MHz clock.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Counts a comparison and reports a mismatch at once.
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask : chk

    // Prints the counts and the verdict, then ends the run.
    task summarize;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    // One single AHB-Lite word transfer; waits on hready in both phases.
    task xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
              output logic [31:0] rdat);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= {22'h000000, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rdat = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : xfer

    task wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] x;
        xfer(1'b1, idx, d, x);
    endtask : wr

    task rd(input logic [7:0] idx, output logic [31:0] d);
        xfer(1'b0, idx, 32'h00000000, d);
    endtask : rd

    // Lets n edges pass and steps past their updates.
    task idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle

    // Pulses a bad write checksum for one cycle.
    task crc_pulse;
        @(posedge clk);
        crc <= 1'b1;
        @(posedge clk);
        crc <= 1'b0;
    endtask : crc_pulse

    // Sends one result and judges the output word one cycle later.
    task send(input logic [23:0] r, input logic [1:0] ch, input logic rf,
              input logic app);
        @(posedge clk);
        rv  <= 1'b1;
        res <= r;
        rch <= ch;
        rng <= rf;
        @(posedge clk);
        rv  <= 1'b0;
        rng <= 1'b0;
        #1;
        chk("out_valid", 32'h1, {31'h0, out_valid});
        chk("status_on", {31'h0, app}, {31'h0, out_st});
        if (app) begin
            chk("out_res", {r, 8'h00}, out_data & 32'hffffff00);
            chk("out_chan", {30'h0, ch}, out_data & 32'h3);
            chk("out_conv", {25'h0, rf, 6'h0}, out_data & 32'h40);
        end else begin
            chk("out_plain", {8'h00, r}, out_data);
        end
        idle(1);
        chk("valid_drop", 32'h0, {31'h0, out_valid});
    endtask : send

    // Reset values, an unmapped index and the idle pin.
    task t_reset;
        rd(`CEFL_IDX_ADCMODE, v);
        chk("adcmode", 32'h2000, v);
        rd(`CEFL_IDX_INTERFACE_MODE_REGISTER, v);
        chk("interface_mode_register", 32'h0, v);
        rd(`CEFL_IDX_PINCFG, v);
        chk("pincfg", 32'h0800, v);
        rd(`CEFL_IDX_CHAN0, v);
        chk("chan0", 32'h8001, v);
        wr(8'h3f, 32'hffffffff);
        rd(8'h3f, v);
        chk("unmapped", 32'h0, v);
        rd(`CEFL_IDX_STATUS, v);
        chk("st_flags", 32'h0, v & 32'h70);
        chk("pin_oe_rst", 32'h0, {31'h0, pin_oe});
    endtask : t_reset

    // Register watch: capture, excluded register, change, hold and clear.
    task t_watch;
        wr(`CEFL_IDX_INTERFACE_MODE_REGISTER, 32'h20);
        idle(2);
        rd(`CEFL_IDX_STATUS, v);
        chk("reg_quiet", 32'h0, v & 32'h10);
        wr(`CEFL_IDX_INTERFACE_MODE_REGISTER, 32'h60);
        wr(`CEFL_IDX_INTERFACE_MODE_REGISTER, 32'h20);
        idle(2);
        rd(`CEFL_IDX_STATUS, v);
        chk("reg_excl", 32'h0, v & 32'h10);
        wr(`CEFL_IDX_ADCMODE, 32'h2004);
        idle(2);
        rd(`CEFL_IDX_STATUS, v);
        chk("reg_set", 32'h10, v & 32'h10);
        idle(4);
        rd(`CEFL_IDX_STATUS, v);
        chk("reg_hold", 32'h10, v & 32'h10);
        wr(`CEFL_IDX_INTERFACE_MODE_REGISTER, 32'h0);
        idle(2);
        rd(`CEFL_IDX_STATUS, v);
        chk("reg_clear", 32'h0, v & 32'h10);
    endtask : t_watch

    // Fault pin in all four functions, watch kept off.
    task t_pins;
        wr(`CEFL_IDX_PINCFG, 32'h0700);
        idle(1);
        chk("gpo_oe", 32'h1, {31'h0, pin_oe});
        chk("gpo_hi", 32'h1, {31'h0, pin_lvl});
        wr(`CEFL_IDX_PINCFG, 32'h0600);
        idle(1);
        chk("gpo_lo", 32'h0, {31'h0, pin_lvl});
        wr(`CEFL_IDX_PINCFG, 32'h0000);
        idle(1);
        chk("off_oe", 32'h0, {31'h0, pin_oe});
        crc_pulse();
        wr(`CEFL_IDX_PINCFG, 32'h0400);
        idle(1);
        chk("err_oe", 32'h1, {31'h0, pin_oe});
        chk("err_low", 32'h0, {31'h0, pin_lvl});
        rd(`CEFL_IDX_STATUS, v);
        chk("err_src", 32'h20, v & 32'h70);
        idle(2);
        chk("err_gone", 32'h1, {31'h0, pin_lvl});
        wr(`CEFL_IDX_PINCFG, 32'h0200);
        ext_err <= 1'b1;
        idle(3);
        chk("in_oe", 32'h0, {31'h0, pin_oe});
        rd(`CEFL_IDX_STATUS, v);
        chk("in_conv", 32'h40, v & 32'h40);
        rd(`CEFL_IDX_PINCFG, v);
        chk("in_lvl0", 32'h0, v & 32'h100);
        ext_err <= 1'b0;
        idle(3);
        rd(`CEFL_IDX_PINCFG, v);
        chk("in_lvl1", 32'h100, v & 32'h100);
        rd(`CEFL_IDX_STATUS, v);
        chk("in_conv0", 32'h0, v & 32'h40);
        wr(`CEFL_IDX_PINCFG, 32'h0000);
    endtask : t_pins

    // Range fault survives a data read; checksum flag clears on status read.
    task t_flags;
        send(24'h123456, 2'h1, 1'b1, 1'b0);
        idle(1);
        rd(`CEFL_IDX_DATA, v);
        chk("data", 32'h123456, v);
        rd(`CEFL_IDX_STATUS, v);
        chk("conv_keep", 32'h40, v & 32'h40);
        crc_pulse();
        idle(1);
        rd(`CEFL_IDX_STATUS, v);
        chk("crc_set", 32'h20, v & 32'h20);
        rd(`CEFL_IDX_STATUS, v);
        chk("crc_clr", 32'h0, v & 32'h20);
    endtask : t_flags

    // Appended status byte for every channel code.
    task t_append;
        wr(`CEFL_IDX_INTERFACE_MODE_REGISTER, 32'h40);
        for (int c = 0; c < 4; c++) begin
            send(24'habcd00 + 24'(c), 2'(c), c > 2, 1'b1);
        end
        wr(`CEFL_IDX_INTERFACE_MODE_REGISTER, 32'h0);
    endtask : t_append

    // Interrupt raised, masked, unmasked and cleared.
    task t_irq;
        wr(`CEFL_IDX_INTSTAT, 32'hf);
        wr(`CEFL_IDX_INTMASK, 32'h2);
        idle(1);
        chk("irq_idle", 32'h0, {31'h0, irq});
        crc_pulse();
        idle(2);
        chk("irq_set", 32'h1, {31'h0, irq});
        wr(`CEFL_IDX_INTMASK, 32'h0);
        idle(1);
        chk("irq_mask", 32'h0, {31'h0, irq});
        wr(`CEFL_IDX_INTMASK, 32'h2);
        idle(1);
        chk("irq_unmask", 32'h1, {31'h0, irq});
        wr(`CEFL_IDX_INTSTAT, 32'h2);
        idle(1);
        chk("irq_clr", 32'h0, {31'h0, irq});
        rd(`CEFL_IDX_INTSTAT, v);
        chk("intstat", 32'h0, v & 32'h2);
    endtask : t_irq

    // Cuts a hang short well beyond the expected run length.
    initial begin
        #200000;
        fail_count++;
        summarize();
    end

    // Reset, then every scenario in turn.
    initial begin
        fail_count = 0;
        num_checks = 0;
        arst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        rv = 1'b0;
        res = 24'h0;
        rch = 2'h0;
        rng = 1'b0;
        crc = 1'b0;
        ext_err = 1'b0;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_watch();
        t_pins();
        t_flags();
        t_append();
        t_irq();
        summarize();
    end
endmodule : cefl_top_tb
`default_nettype wire
